// File: rtl/ptt_pkg.sv
package ptt_pkg;
	// -------------------------------------------------------------
	// Register map (byte addresses)
	// -------------------------------------------------------------
	localparam logic [3:0] PTT_OFF_CTRL = 4'h0;
	localparam logic [3:0] PTT_OFF_PERIOD = 4'h4;
	localparam logic [3:0] PTT_OFF_CURRENT = 4'h8;
	localparam logic [3:0] PTT_OFF_STATUS = 4'hC;
	// -------------------------------------------------------------
	// Field positions and reset values
	// -------------------------------------------------------------
	localparam int PTT_CTRL_RUN_BIT = 0;
	localparam int PTT_CTRL_IEN_BIT = 1;
	localparam int PTT_STAT_ROLL_BIT = 0;
	localparam int PTT_CNT_W = 24;
	localparam logic [23:0] PTT_PERIOD_RST = 24'h000000;
	localparam logic [23:0] PTT_COUNT_RST = 24'h000000;
	typedef struct packed {
		logic irq_en;
		logic run;
	} ptt_ctrl_t;
endpackage

// File: rtl/ptt_counter.sv
`timescale 1ns/1ps
`default_nettype none
module ptt_counter #(
	parameter int W = 24
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Control
	input wire logic run,
	input wire logic clear,
	input wire logic [W-1:0] period,
	// State
	output logic [W-1:0] count,
	output logic roll
);
	logic [W-1:0] count_q, count_d;
	logic reload_q, reload_d;

	always_comb begin
		count_d = count_q;
		reload_d = reload_q;
		roll = 1'b0;
		if (clear) begin
			count_d = '0;
			reload_d = 1'b1;
		end else if (run) begin
			reload_d = 1'b0;
			if (reload_q) begin
				count_d = period - 1'b1;
			end else if (count_q == '0) begin
				count_d = period - 1'b1;
				roll = 1'b1;
			end else begin
				count_d = count_q - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			count_q <= '0;
			reload_q <= 1'b0;
		end else begin
			count_q <= count_d;
			reload_q <= reload_d;
		end
	end

	assign count = count_q;
endmodule
`default_nettype wire

// File: rtl/ptt_timer.sv
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ptt_timer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Interrupt controller side
	input wire logic handler_enter,
	output logic irq
);
	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	ptt_pkg::ptt_ctrl_t ctrl_q, ctrl_d;
	logic [23:0] period_q, period_d;
	logic stat_q, stat_d;
	logic mask_q, mask_d;
	logic [31:0] rdata_q, rdata_d;
	logic ack_q, ack_d;
	logic [23:0] count;
	logic roll;
	logic wr, cur_wr;

	// One wait cycle, then acknowledge
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	// Write lands at the edge where waitrequest is seen low
	assign wr = avs_write & ack_q;
	assign cur_wr = wr && avs_address == ptt_pkg::PTT_OFF_CURRENT;

	ptt_counter #(.W(ptt_pkg::PTT_CNT_W)) u_cnt (
		.clk_sys(clk_sys),
		.reset(reset),
		.run(ctrl_q.run),
		.clear(cur_wr),
		.period(period_q),
		.count(count),
		.roll(roll)
	);

	always_comb begin
		ctrl_d = ctrl_q;
		period_d = period_q;
		mask_d = mask_q;
		stat_d = stat_q;
		ack_d = (avs_read | avs_write) & ~ack_q;
		rdata_d = rdata_q;
		if (wr) begin
			case (avs_address)
				ptt_pkg::PTT_OFF_CTRL: begin
					if (avs_byteenable[0]) begin
						ctrl_d.run = avs_writedata[ptt_pkg::PTT_CTRL_RUN_BIT];
						ctrl_d.irq_en = avs_writedata[ptt_pkg::PTT_CTRL_IEN_BIT];
						mask_d = avs_writedata[ptt_pkg::PTT_CTRL_IEN_BIT];
					end
				end
				ptt_pkg::PTT_OFF_PERIOD: begin
					// No reload here: the count runs on
					for (int i = 0; i < 3; i++) begin
						if (avs_byteenable[i]) begin
							period_d[i*8 +: 8] = avs_writedata[i*8 +: 8];
						end
					end
				end
				ptt_pkg::PTT_OFF_STATUS: begin
					if (avs_byteenable[0] && avs_writedata[ptt_pkg::PTT_STAT_ROLL_BIT]) begin
						stat_d = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// Handler entry clears pending; a new rollover wins
		if (handler_enter) begin
			stat_d = 1'b0;
		end
		if (roll) begin
			stat_d = 1'b1;
		end
		if (avs_read & ~ack_q) begin
			case (avs_address)
				ptt_pkg::PTT_OFF_CTRL: rdata_d = {30'h0000000, ctrl_q.irq_en, ctrl_q.run};
				ptt_pkg::PTT_OFF_PERIOD: rdata_d = {8'h00, period_q};
				ptt_pkg::PTT_OFF_CURRENT: rdata_d = {8'h00, count};
				ptt_pkg::PTT_OFF_STATUS: rdata_d = {31'h0000000, stat_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_q <= '0;
			mask_q <= 1'b0;
			period_q <= ptt_pkg::PTT_PERIOD_RST;
			stat_q <= 1'b0;
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			period_q <= period_d;
			stat_q <= stat_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata = rdata_q;
	// Stopped counter never rolls, so no tick while halted
	assign irq = stat_q & mask_q;
endmodule
`default_nettype wire

// File: verification/ptt_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ptt_timer_sva (
	// Bus and interrupt side
	input wire logic clk_sys, reset, avs_read, avs_write,
	input wire logic [3:0] avs_address, avs_byteenable,
	input wire logic [31:0] avs_writedata, avs_readdata,
	input wire logic avs_waitrequest, handler_enter, irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire logic req = avs_read | avs_write;
	chk_wait_first: assert property ($rose(req) |-> avs_waitrequest)
		else $error("no wait on first cycle");
	chk_ack_next: assert property (req && avs_waitrequest |=>
		!avs_waitrequest) else $error("late answer");
	chk_idle_ready: assert property (!req |-> !avs_waitrequest)
		else $error("wait while idle");
	chk_reset_quiet: assert property (disable iff (1'b0)
		reset |=> !irq) else $error("irq after reset");
	chk_ien_gate: assert property (avs_write && !avs_waitrequest
		&& avs_address == ptt_pkg::PTT_OFF_CTRL && avs_byteenable[0]
		&& !avs_writedata[1] |=> !irq [*3]) else $error("irq ungated");
	chk_unmapped_zero: assert property (avs_read && avs_waitrequest
		&& avs_address[1:0] != 2'h0 |=> avs_readdata == 32'h0)
		else $error("unmapped read");
	chk_period_width: assert property (avs_read && avs_waitrequest
		&& avs_address == ptt_pkg::PTT_OFF_PERIOD
		|=> avs_readdata[31:24] == 8'h00) else $error("period width");
	chk_data_stable: assert property (!avs_read |=>
		$stable(avs_readdata)) else $error("read data moved");
endmodule
bind ptt_timer ptt_timer_sva i_sva (.clk_sys, .reset, .avs_read,
	.avs_write, .avs_address, .avs_byteenable, .avs_writedata,
	.avs_readdata, .avs_waitrequest, .handler_enter, .irq);
`default_nettype wire

// File: verification/tb_ptt_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ptt_timer;
	logic clk_sys = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic handler_enter = 1'b0, avs_waitrequest, irq;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	int error_cnt = 0, num_checks = 0, seed = 32'h5FFC3FF3, p, n, c;
	always #2 clk_sys = ~clk_sys;
	ptt_timer i_dut (.clk_sys, .reset, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.handler_enter, .irq);
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %0t seen %h want %h", $time, s, e);
		end
	endtask
	// Hazard: a hung slave must end the run, so every wait is bounded
	task automatic bus(input logic w, input logic [3:0] a, input int d);
		int k;
		k = 0;
		@(posedge clk_sys);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		#1;
		while (avs_waitrequest !== 1'b0 && k < 20) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		if (k >= 20) begin
			error_cnt++;
			summarize();
		end
		@(posedge clk_sys);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		#1;
	endtask
	task automatic wirq(output int m);
		m = 0;
		while (irq !== 1'b1 && m < 100) begin
			@(posedge clk_sys);
			#1;
			m++;
		end
		if (m >= 100) begin
			error_cnt++;
			summarize();
		end
	endtask
	initial begin
		p = 3 + {$random(seed)} % 6;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		bus(0, ptt_pkg::PTT_OFF_CTRL, 0);
		chk(q, 0);
		bus(0, 4'h1, 0);
		chk(q, 0);
		bus(1, ptt_pkg::PTT_OFF_PERIOD, p);
		bus(0, ptt_pkg::PTT_OFF_PERIOD, 0);
		chk(q, p);
		bus(1, ptt_pkg::PTT_OFF_CURRENT, $random(seed));
		bus(0, ptt_pkg::PTT_OFF_CURRENT, 0);
		chk(q, 0);
		$display("registers done");
		bus(1, ptt_pkg::PTT_OFF_CTRL, 3);
		wirq(n);
		@(posedge clk_sys);
		handler_enter <= 1'b1;
		@(posedge clk_sys);
		handler_enter <= 1'b0;
		#1;
		chk(irq, 0);
		wirq(n);
		chk(n + 2, p);
		bus(1, ptt_pkg::PTT_OFF_CTRL, 1);
		repeat (2 * p) @(posedge clk_sys);
		chk(irq, 0);
		bus(0, ptt_pkg::PTT_OFF_STATUS, 0);
		chk(q, 1);
		$display("period done");
		bus(1, ptt_pkg::PTT_OFF_CTRL, 0);
		bus(1, ptt_pkg::PTT_OFF_STATUS, 1);
		bus(1, ptt_pkg::PTT_OFF_CTRL, 2);
		bus(0, ptt_pkg::PTT_OFF_CURRENT, 0);
		c = q;
		chk(c < p, 1);
		repeat (3 * p) @(posedge clk_sys);
		chk(irq, 0);
		bus(0, ptt_pkg::PTT_OFF_CURRENT, 0);
		chk(q, c);
		bus(1, ptt_pkg::PTT_OFF_CTRL, 3);
		wirq(n);
		chk(n <= c + 3, 1);
		$display("stop done");
		summarize();
	end
endmodule
`default_nettype wire
